// >>> rtl/bdp_pkg.sv
// bdp_pkg: constants, types and helpers for the backlight dimming pwm block
// assumes one 40 MHz system clock; all command bytes arrive synchronously
package bdp_pkg;

   // command codes and reset values of the configuration bytes
   localparam logic [7:0] CMD_DIM_MS  = 8'hCD;
   localparam logic [7:0] CMD_UI_RAMP_TIME_CODE  = 8'hCE;
   localparam logic [7:0] CMD_PWM_DIV = 8'hCF;
   localparam logic [7:0] RST_DIM_MS  = 8'h43;
   localparam logic [7:0] RST_UI_RAMP_TIME_CODE  = 8'h02;
   localparam logic [7:0] RST_PWM_DIV = 8'h00;
   // zero bits of each parameter byte are forced clear on write
   localparam logic [7:0] MASK_DIM_MS = 8'h77;
   localparam logic [7:0] MASK_UI_RAMP_TIME_CODE = 8'hF7;

   // field positions
   localparam int FLD_MOV_LSB   = 4;
   localparam int FLD_STILL_LSB = 0;
   localparam int FLD_UI_LSB    = 0;
   localparam int FLD_MIN_LSB   = 4;

   // reference rate as a fraction of the system clock, in kHz
   localparam logic [15:0] REF_KHZ = 16'd18000;
   localparam logic [15:0] CLK_KHZ = 16'd40000;
   // a pwm period has 255 steps, numbered 0 to 254
   localparam logic [7:0]  PWM_LAST_STEP = 8'hFE;

   typedef enum logic [1:0] {
      MODE_MOVING = 2'b00,
      MODE_STILL  = 2'b01,
      MODE_UI     = 2'b11
   } bdp_mode_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RAMP = 1'b1
   } bdp_state_t;

   typedef struct packed {
      logic [2:0] moving;
      logic [2:0] still;
      logic [2:0] ui;
      logic [3:0] min_step;
      logic [7:0] divider;
   } bdp_cfg_t;

   // per-frame step so that a change of delta ends within the coded frames:
   // 2, 3, then 4, 8 .. 128 (ceiling, so the ramp never overruns its span)
   function automatic logic [7:0] bdp_ramp_step(input logic [2:0] code,
                                                input logic [7:0] delta);
      logic [8:0]  d;
      logic [17:0] prod;
      logic [8:0]  res;
      d    = {1'b0, delta};
      prod = 18'h00000;
      res  = 9'h000;
      case (code)
         3'h0: res = (d + 9'h001) >> 1;
         3'h1: begin
            prod = 18'((d + 9'h002) * 9'd171);
            res  = prod[17:9];
         end
         default: res = (d + ((9'h001 << code) - 9'h001)) >> code;
      endcase
      return res[7:0];
   endfunction : bdp_ramp_step

endpackage : bdp_pkg

// >>> rtl/bdp_pwm_gen.sv
// bdp_pwm_gen: 255-step brightness pwm paced by an 18 MHz reference enable
// assumes divider and duty are quasi-static; both are sampled per period
`timescale 1ns/100ps
`default_nettype none
module bdp_pwm_gen
   import bdp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic [7:0] divider,
   input  wire logic [7:0] duty,
   output var  logic       pwm_out_q
);
   logic [15:0] acc_q;
   logic [16:0] acc_sum;
   logic        ref_tick;
   logic [7:0]  pre_q;
   logic [7:0]  step_q;
   logic [7:0]  div_lat_q;
   logic [7:0]  duty_lat_q;
   logic        step_tick;
   logic        boundary;

   // fractional accumulator: 18 of every 40 clocks carry a reference tick
   assign acc_sum  = {1'b0, acc_q} + {1'b0, REF_KHZ};
   assign ref_tick = (acc_sum >= {1'b0, CLK_KHZ});
   assign step_tick = ref_tick && (pre_q == div_lat_q);
   assign boundary  = step_tick && (step_q == PWM_LAST_STEP);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         acc_q <= 16'h0000;
      end else if (ref_tick) begin
         acc_q <= 16'(acc_sum - {1'b0, CLK_KHZ});
      end else begin
         acc_q <= acc_sum[15:0];
      end
   end

   // prescaler of divider+1 reference ticks per step
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pre_q <= 8'h00;
      end else if (step_tick) begin
         pre_q <= 8'h00;
      end else if (ref_tick) begin
         pre_q <= pre_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         step_q <= 8'h00;
      end else if (boundary) begin
         step_q <= 8'h00;
      end else if (step_tick) begin
         step_q <= step_q + 8'h01;
      end
   end

   // new settings only at a period boundary, so no period is cut short
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_lat_q  <= RST_PWM_DIV;
         duty_lat_q <= 8'h00;
      end else if (boundary) begin
         div_lat_q  <= divider;
         duty_lat_q <= duty;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pwm_out_q <= 1'b0;
      end else begin
         pwm_out_q <= (step_q < duty_lat_q);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   step_wrap_a: assert property (boundary |=> step_q == 8'h00)
      else $error("pwm step did not wrap after 255 steps");
   prescale_bound_a: assert property (pre_q <= div_lat_q)
      else $error("prescaler ran past divider");
   latch_hold_a: assert property (!boundary |=> $stable(div_lat_q))
      else $error("divider changed inside a period");
   duty_out_a: assert property (##1 pwm_out_q ==
      ($past(step_q) < $past(duty_lat_q)))
      else $error("pwm level disagrees with duty");
   tick_rate_a: assert property (ref_tick |=> !ref_tick)
      else $error("reference ticks back to back");
   period_cov: cover property (boundary ##1 step_q == 8'h00);
endmodule : bdp_pwm_gen
`default_nettype wire

// >>> rtl/bdp_top.sv
// bdp_top: backlight dimming configuration, brightness ramp and pwm output
// assumes host bus strobes, frame_tick and mode are synchronous to clk_sys
// Operation
// - command bytes have the select low, parameters high, taken on write rise with read high, upper lines ignored.
// - command CDh takes one byte: moving code in 6:4, still code in 2:0, 7 and 3 zero, reset 43h.
// - in still mode a brightness change is spread over the still-code transition time.
// - separate codes for moving, still and ui modes; only the active mode's code is used.
// - codes map to 2, 3, 4-6, 8-12, 16-24, 32-48, 64-96, 128-192 frames.
// - command CEh takes one byte: threshold in 7:4, bit 3 zero, ui code in 2:0, reset 02h.
// - in ui mode a change ramps over the ui-code time with the same encoding.
// - if the threshold exceeds the target-current distance the brightness stays.
// - command CFh takes one 8-bit pwm divider setting the output period.
// - pwm frequency is 18 MHz over (divider+1) times 255.
// - the three commands are taken in every power mode, sleep included.
`timescale 1ns/100ps
`default_nettype none
module bdp_top
   import bdp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        cmd_param_select,
   input  wire logic        write_strobe_n,
   input  wire logic        read_strobe_n,
   input  wire logic [23:0] bus_data,
   input  wire logic        frame_tick,
   input  wire bdp_pkg::bdp_mode_t content_mode,
   input  wire logic [7:0]  target_brightness,
   output var  logic [7:0]  current_brightness_q,
   output var  logic        ramp_active_q,
   output var  logic        backlight_pwm_out
);
   import bdp_pkg::*;

   logic       wr_n_prev_q;
   logic       wr_rise;
   logic       wr_cmd;
   logic       wr_param;
   logic [7:0] byte_in;
   logic [7:0] cmd_q;
   logic       param_pend_q;
   logic [7:0] dimming_time_moving_still_q;
   logic [7:0] dimming_time_ui_min_step_q;
   logic [7:0] brightness_pwm_divider_q;
   bdp_cfg_t   cfg;
   bdp_state_t state_q;
   logic [7:0] goal_q;
   logic [7:0] step_q;
   logic [7:0] diff;
   logic [7:0] remain;
   logic [2:0] sel_code;
   logic       start_ramp;

   // only the low byte carries data; the upper lines are ignored
   assign byte_in  = bus_data[7:0];
   assign wr_rise  = write_strobe_n && !wr_n_prev_q && read_strobe_n;
   assign wr_cmd   = wr_rise && !cmd_param_select;
   assign wr_param = wr_rise && cmd_param_select && param_pend_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_n_prev_q <= 1'b1;
      end else begin
         wr_n_prev_q <= write_strobe_n;
      end
   end

   // no power-mode input gates these writes, so sleep accepts them too
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cmd_q        <= 8'h00;
         param_pend_q <= 1'b0;
      end else if (wr_cmd) begin
         cmd_q        <= byte_in;
         param_pend_q <= 1'b1;
      end else if (wr_param) begin
         param_pend_q <= 1'b0;
      end
   end

   // each command takes one parameter; further bytes are dropped
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dimming_time_moving_still_q <= RST_DIM_MS;
         dimming_time_ui_min_step_q  <= RST_UI_RAMP_TIME_CODE;
         brightness_pwm_divider_q    <= RST_PWM_DIV;
      end else if (wr_param) begin
         case (cmd_q)
            CMD_DIM_MS:
               dimming_time_moving_still_q <= byte_in & MASK_DIM_MS;
            CMD_UI_RAMP_TIME_CODE:
               dimming_time_ui_min_step_q  <= byte_in & MASK_UI_RAMP_TIME_CODE;
            CMD_PWM_DIV:
               brightness_pwm_divider_q    <= byte_in;
            default: ;
         endcase
      end
   end

   assign cfg.moving   = dimming_time_moving_still_q[FLD_MOV_LSB +: 3];
   assign cfg.still    = dimming_time_moving_still_q[FLD_STILL_LSB +: 3];
   assign cfg.ui       = dimming_time_ui_min_step_q[FLD_UI_LSB +: 3];
   assign cfg.min_step = dimming_time_ui_min_step_q[FLD_MIN_LSB +: 4];
   assign cfg.divider  = brightness_pwm_divider_q;

   // the code is chosen by the mode active when the ramp starts
   always_comb begin
      case (content_mode)
         MODE_STILL: sel_code = cfg.still;
         MODE_UI:    sel_code = cfg.ui;
         default:    sel_code = cfg.moving;
      endcase
   end

   assign diff = (current_brightness_q > target_brightness) ?
                 current_brightness_q - target_brightness :
                 target_brightness - current_brightness_q;
   assign remain = (current_brightness_q > goal_q) ?
                   current_brightness_q - goal_q :
                   goal_q - current_brightness_q;
   // small changes below the threshold are suppressed entirely
   assign start_ramp = frame_tick && (state_q == ST_IDLE) &&
                       (diff != 8'h00) && ({4'h0, cfg.min_step} <= diff);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: if (start_ramp) state_q <= ST_RAMP;
            ST_RAMP: if (frame_tick && remain <= step_q) state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // goal and step are frozen for the ramp; a later target waits its turn
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         goal_q <= 8'h00;
         step_q <= 8'h01;
      end else if (start_ramp) begin
         goal_q <= target_brightness;
         step_q <= bdp_ramp_step(sel_code, diff);
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         current_brightness_q <= 8'h00;
      end else if (frame_tick && state_q == ST_RAMP) begin
         if (remain <= step_q) begin
            current_brightness_q <= goal_q;
         end else if (current_brightness_q > goal_q) begin
            current_brightness_q <= current_brightness_q - step_q;
         end else begin
            current_brightness_q <= current_brightness_q + step_q;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ramp_active_q <= 1'b0;
      end else begin
         ramp_active_q <= (state_q == ST_RAMP) ||
                          (start_ramp && !(frame_tick && state_q == ST_RAMP));
      end
   end

   bdp_pwm_gen u_pwm (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .divider   (cfg.divider),
      .duty      (current_brightness_q),
      .pwm_out_q (backlight_pwm_out)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   cmd_latch_a: assert property (wr_cmd |=>
      cmd_q == $past(bus_data[7:0]) && param_pend_q)
      else $error("command byte not latched");
   read_block_a: assert property (!read_strobe_n |=>
      $stable(cmd_q) && $stable(brightness_pwm_divider_q))
      else $error("write taken while read strobe low");
   dim_ms_write_a: assert property (wr_param && cmd_q == CMD_DIM_MS |=>
      dimming_time_moving_still_q == ($past(bus_data[7:0]) & 8'h77))
      else $error("moving/still byte wrong");
   ui_ramp_time_code_write_a: assert property (wr_param && cmd_q == CMD_UI_RAMP_TIME_CODE |=>
      dimming_time_ui_min_step_q == ($past(bus_data[7:0]) & 8'hF7))
      else $error("ui/threshold byte wrong");
   div_write_a: assert property (wr_param && cmd_q == CMD_PWM_DIV |=>
      brightness_pwm_divider_q == $past(bus_data[7:0]))
      else $error("divider byte wrong");
   one_param_a: assert property (wr_param |=> !param_pend_q)
      else $error("second parameter byte accepted");
   thresh_hold_a: assert property (frame_tick && state_q == ST_IDLE &&
      ({4'h0, cfg.min_step} > diff) |=> state_q == ST_IDLE &&
      $stable(current_brightness_q))
      else $error("brightness moved under threshold");
   ramp_step_a: assert property (frame_tick && state_q == ST_RAMP |=>
      (current_brightness_q == goal_q) ||
      (current_brightness_q - $past(current_brightness_q) == step_q) ||
      ($past(current_brightness_q) - current_brightness_q == step_q))
      else $error("ramp step size wrong");
   still_code_a: assert property (start_ramp && content_mode == MODE_STILL
      |=> step_q == bdp_ramp_step($past(cfg.still), $past(diff)))
      else $error("still ramp used wrong code");
   ui_code_a: assert property (start_ramp && content_mode == MODE_UI
      |=> step_q == bdp_ramp_step($past(cfg.ui), $past(diff)))
      else $error("ui ramp used wrong code");
   ramp_cov: cover property (start_ramp ##[1:600] state_q == ST_IDLE);
   cmd_cov: cover property (wr_cmd ##[1:20] wr_param);
   ui_cov: cover property (start_ramp && content_mode == MODE_UI);
endmodule : bdp_top
`default_nettype wire

// >>> test/bdp_host_model.sv
// bdp_host_model: host side of the display command bus, byte writes only
// assumes the bench calls its tasks; lines move on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module bdp_host_model (
   input  wire logic        clk_sys,
   output var  logic        cmd_param_select,
   output var  logic        write_strobe_n,
   output var  logic        read_strobe_n,
   output var  logic [23:0] bus_data
);
   initial begin
      cmd_param_select = 1'b0;
      write_strobe_n   = 1'b1;
      read_strobe_n    = 1'b1;
      bus_data         = 24'h000000;
   end

   task automatic wr(input logic sel, input logic [7:0] data,
                     input logic rd_low);
      @(negedge clk_sys);
      cmd_param_select = sel;
      read_strobe_n    = ~rd_low;
      bus_data         = {16'($urandom), data};
      write_strobe_n   = 1'b0;
      @(negedge clk_sys);
      write_strobe_n   = 1'b1;
      @(negedge clk_sys);
      // released lines show the inverse so a stale byte is never trusted
      bus_data         = ~bus_data;
      read_strobe_n    = 1'b1;
   endtask : wr

   // no power-mode setup precedes a write: all modes accept these commands
   task automatic cmd(input logic [7:0] code, input logic [7:0] param,
                      input logic refuse);
      wr(1'b0, code, 1'b0);
      wr(1'b1, param, refuse);
   endtask : cmd
endmodule : bdp_host_model
`default_nettype wire

// >>> test/backlight_dimming_pwm_ctrl_bench.sv
// bench for bdp_top: random ramps in every mode and code, threshold edges,
// pwm period and duty; assumes bdp_host_model drives the command bus
`timescale 1ns/100ps
`default_nettype none
module backlight_dimming_pwm_ctrl_bench;
   import bdp_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        frame_tick = 1'b0;
   bdp_mode_t   content_mode = MODE_MOVING;
   logic [7:0]  target_brightness = 8'h00;
   wire logic   cmd_param_select;
   wire logic   write_strobe_n;
   wire logic   read_strobe_n;
   wire logic [23:0] bus_data;
   wire logic [7:0]  current_brightness_q;
   wire logic   ramp_active_q;
   wire logic   backlight_pwm_out;
   int          error_cnt = 0;
   int          n_checks = 0;
   int          i;
   logic [7:0]  t;
   logic [7:0]  exp_b = 8'h00;
   logic [2:0]  mv = RST_DIM_MS[6:4];
   logic [2:0]  st = RST_DIM_MS[2:0];
   logic [2:0]  ui = RST_UI_RAMP_TIME_CODE[2:0];
   logic [3:0]  mn = RST_UI_RAMP_TIME_CODE[7:4];
   bdp_mode_t   tab [3] = '{MODE_MOVING, MODE_STILL, MODE_UI};

   always #12.5 clk_sys = ~clk_sys;

   bdp_host_model i_host (
      .clk_sys(clk_sys), .cmd_param_select(cmd_param_select),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .bus_data(bus_data));

   bdp_top i_dut (
      .clk_sys(clk_sys), .reset(reset),
      .cmd_param_select(cmd_param_select), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .bus_data(bus_data),
      .frame_tick(frame_tick), .content_mode(content_mode),
      .target_brightness(target_brightness),
      .current_brightness_q(current_brightness_q),
      .ramp_active_q(ramp_active_q), .backlight_pwm_out(backlight_pwm_out));

   task automatic results();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // ceiling step so that a change of d ends within the coded frame count
   function automatic logic [7:0] exp_step(input logic [2:0] c,
                                           input int d);
      if (c == 3'h1)
         return 8'((d + 2) / 3);
      return 8'((d + (c == 3'h0 ? 2 : (1 << c)) - 1) /
                (c == 3'h0 ? 2 : (1 << c)));
   endfunction : exp_step

   task automatic tick();
      @(negedge clk_sys);
      frame_tick = 1'b1;
      @(negedge clk_sys);
      frame_tick = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask : tick

   task automatic setcfg(input logic [7:0] ms, input logic [7:0] um,
                         input logic refuse);
      i_host.cmd(CMD_DIM_MS, ms, refuse);
      i_host.cmd(CMD_UI_RAMP_TIME_CODE, um, refuse);
      if (!refuse) begin
         mv = ms[6:4];
         st = ms[2:0];
         ui = um[2:0];
         mn = um[7:4];
      end
   endtask : setcfg

   task automatic ramp(input bdp_mode_t m, input logic [7:0] tg);
      logic [2:0] c;
      logic [7:0] step;
      int d;
      int k;
      c = (m == MODE_STILL) ? st : ((m == MODE_UI) ? ui : mv);
      d = (tg > exp_b) ? int'(tg - exp_b) : int'(exp_b - tg);
      @(negedge clk_sys);
      content_mode = m;
      target_brightness = tg;
      tick();
      if (d == 0 || int'(mn) > d) begin
         check(current_brightness_q, exp_b);
         check({7'h00, ramp_active_q}, 8'h00);
         return;
      end
      check({7'h00, ramp_active_q}, 8'h01);
      step = exp_step(c, d);
      for (k = 0; k < 200 && exp_b != tg; k++) begin
         tick();
         if (tg > exp_b)
            exp_b = (tg - exp_b <= step) ? tg : exp_b + step;
         else
            exp_b = (exp_b - tg <= step) ? tg : exp_b - step;
         check(current_brightness_q, exp_b);
      end
      // the ramp flag drops one clock after the last frame step
      check({7'h00, ramp_active_q}, 8'h00);
      check(8'(k <= (c == 3'h1 ? 3 : (c == 3'h0 ? 2 : (1 << c)))),
            8'h01);
   endtask : ramp

   task automatic pwm_rise();
      logic prev;
      int k;
      prev = 1'b1;
      for (k = 0; k < 6000; k++) begin
         @(posedge clk_sys);
         #1;
         if (!prev && backlight_pwm_out === 1'b1)
            return;
         prev = backlight_pwm_out;
      end
      error_cnt++;
      results();
   endtask : pwm_rise

   task automatic pwm_meas(input logic [7:0] div);
      int hi;
      int per;
      logic lo_seen;
      real ep;
      real eh;
      i_host.cmd(CMD_PWM_DIV, div, 1'b0);
      // the period running at the write keeps its old divider
      repeat (3) pwm_rise();
      hi = 1;
      per = 1;
      lo_seen = 1'b0;
      while (per < 6000) begin
         @(posedge clk_sys);
         #1;
         if (backlight_pwm_out === 1'b1 && lo_seen)
            break;
         if (backlight_pwm_out !== 1'b1)
            lo_seen = 1'b1;
         else
            hi++;
         per++;
      end
      ep = 255.0 * (div + 1) * CLK_KHZ / REF_KHZ;
      eh = real'(exp_b) * (div + 1) * CLK_KHZ / REF_KHZ;
      check(8'(per > ep - 3.0 && per < ep + 3.0), 8'h01);
      check(8'(hi > eh - 3.0 && hi < eh + 3.0), 8'h01);
   endtask : pwm_meas

   initial begin
      void'($urandom(32'h869C));
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      // ui ramp on the reset value of the ui byte, before any write
      ramp(MODE_UI, 8'h20);
      for (i = 0; i < 14; i++) begin
         if (i >= 1 && i <= 8)
            setcfg({1'b1, 3'(8 - i), 1'b1, 3'(i - 1)},
                   {4'h0, 1'b1, 3'(i - 1)}, 1'b0);
         else if (i > 8)
            setcfg(8'($urandom), 8'($urandom), $urandom_range(3) == 0);
         t = 8'($urandom);
         if (t == exp_b)
            t = ~t;
         ramp(tab[i % 3], t);
      end
      setcfg(8'h00, 8'h40, 1'b0);
      ramp(MODE_UI, exp_b < 8'h80 ? exp_b + 8'h03 : exp_b - 8'h03);
      ramp(MODE_UI, exp_b < 8'h80 ? exp_b + 8'h04 : exp_b - 8'h04);
      setcfg(8'h00, 8'h00, 1'b0);
      // the unused mode code must fall back to the moving code
      ramp(bdp_mode_t'(2'h2), 8'h10);
      ramp(MODE_STILL, 8'h80);
      pwm_meas(8'h00);
      pwm_meas(8'h03);
      results();
   end
endmodule : backlight_dimming_pwm_ctrl_bench
`default_nettype wire
